// ===== common/evt_timer_pkg.sv
// Shared constants and types of the off-loadable event timer
package evt_timer_pkg;

    localparam int NUM_TIMERS = 8;
    localparam int CNT_W      = 64;
    localparam int FRAC_W     = 18;
    localparam int SLOW_W     = 82;
    localparam int CAL_W      = 28;
    localparam int STRAP_W    = 2;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses), timer page and field selects
    // -------------------------------------------------------------------
    localparam logic [11:0] GEN_CTRL_OFS  = 12'h000;
    localparam logic [11:0] GEN_STAT_OFS  = 12'h004;
    localparam logic [11:0] COUNT_LO_OFS  = 12'h008;
    localparam logic [11:0] COUNT_HI_OFS  = 12'h00c;
    localparam logic [3:0]  TMR_PAGE      = 4'h1;
    localparam logic [1:0]  TMR_CFG_FLD   = 2'h0;
    localparam logic [1:0]  TMR_CMPLO_FLD = 2'h2;
    localparam logic [1:0]  TMR_CMPHI_FLD = 2'h3;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_LEGACY_BIT = 1;
    localparam int STAT_SLOW_BIT   = 8;
    localparam int STAT_PARK_BIT   = 9;
    localparam int STAT_STRAP_LSB  = 10;
    localparam int STAT_BUSY_BIT   = 12;
    localparam int CFG_INT_EN_BIT  = 0;
    localparam int CFG_PERIOD_BIT  = 1;

    // -------------------------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------------------------
    localparam logic [CNT_W-1:0]  COUNT_RST = 64'h0;
    localparam logic [SLOW_W-1:0] SLOW_RST  = 82'h0;
    localparam logic [CNT_W-1:0]  CMP_RST   = 64'hffff_ffff_ffff_ffff;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MAX_TICK_NS   = 100;
    localparam int MAX_TICK_CYC  = (MAX_TICK_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_FAST   = 3'b001,
        ST_PARKED = 3'b010,
        ST_SLOW   = 3'b100
    } mode_e;

endpackage : evt_timer_pkg

// ===== common/rtc_edge_if.sv
// Carries the synchronised slow-clock rising edge into the timer core
interface rtc_edge_if;
    logic rise;
    modport src (output rise);
    modport dst (input rise);
endinterface : rtc_edge_if

// ===== core/rtc_edge_sync.sv
// Two-flop synchroniser and rising-edge detector for the slow clock
module rtc_edge_sync
    import evt_timer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rtc_clk,
    rtc_edge_if.src   edge_out
);

    logic sync1;
    logic sync2;
    logic prev;
    logic rise;
    logic next_rise;

    // Edge is taken from the second and third stage only
    always_comb begin
        next_rise = sync2 & ~prev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev  <= 1'b0;
            rise  <= 1'b0;
        end else begin
            sync1 <= rtc_clk;
            sync2 <= sync1;
            prev  <= sync2;
            rise  <= next_rise;
        end
    end

    assign edge_out.rise = rise;

endmodule : rtc_edge_sync

// ===== core/offload_event_timer.sv
// Event timer core: main counter, eight comparators, slow-clock off-load
// Function
// RQ1: eight comparators share one counter, raise interrupts
// RQ2: only timer 0 may run periodic
// RQ3: main counter only ever counts upward
// RQ4: tick at most 100 ns, drift two ticks
// RQ5: crystal clocks counter, strap picks frequency
// RQ6: fast count adds one per enabled edge
// RQ7: no off-load while any comparator armed
// RQ8: controller holds off-load request through deepest idle
// RQ9: request only without wake events, calibrator idle
// RQ10: slow count adds 28-bit calibration step
// RQ11: mode switches only on slow rising edge
// RQ12: request and slow indication in fast domain
// RQ13: slow clock sampled through two flops
// RQ14: entry copies fast count to upper bits
// RQ15: first edge parks, next edges add step
// RQ16: exit reloads fast count, then drops indication (the code does both on the same slow edge)
// RQ17: fraction bits kept across later entries
// RQ18: early exit does both switches one edge
// RQ19: software masks before clearing legacy route select
// RQ20: slow mode reads return upper slow bits
//
// Design decisions made here: the APB register port and the address map.
module offload_event_timer
    import evt_timer_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               rtc_clk,
    input  wire logic               offload_req,
    input  wire logic [CAL_W-1:0]   cal_step,
    input  wire logic [STRAP_W-1:0] xtal_freq_strap,
    output logic                    slow_mode_active,
    output logic [NUM_TIMERS-1:0]   timer_irq,
    output logic                    legacy_route_sel
);

    // -------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------
    function automatic logic is_tmr(input logic [11:0] a);
        return (a[11:8] == TMR_PAGE) && !a[4];
    endfunction : is_tmr

    rtc_edge_if rtc_edge ();
    rtc_edge_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .rtc_clk  (rtc_clk),
        .edge_out (rtc_edge)
    );

    logic                  slow_rise;
    logic                  acc;
    logic                  wr;
    logic [2:0]            tidx;
    logic [1:0]            tfld;
    mode_e                 state;
    mode_e                 next_state;
    logic [CNT_W-1:0]      fast_cnt;
    logic [CNT_W-1:0]      next_fast;
    logic [SLOW_W-1:0]     slow_cnt;
    logic [SLOW_W-1:0]     next_slow;
    logic                  next_active;
    logic                  count_en;
    logic                  next_count_en;
    logic                  next_legacy;
    logic [CNT_W-1:0]      cmp [NUM_TIMERS];
    logic [CNT_W-1:0]      next_cmp [NUM_TIMERS];
    logic [CNT_W-1:0]      period0;
    logic [CNT_W-1:0]      next_period0;
    logic [NUM_TIMERS-1:0] int_en;
    logic [NUM_TIMERS-1:0] next_int_en;
    logic                  periodic0;
    logic                  next_periodic0;
    logic [NUM_TIMERS-1:0] hit;
    logic [NUM_TIMERS-1:0] next_hit;
    logic [NUM_TIMERS-1:0] next_irq;
    logic [NUM_TIMERS-1:0] match;
    logic                  cmp_active;
    logic [31:0]           next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    logic [STRAP_W-1:0]    strap_s1;
    logic [STRAP_W-1:0]    strap_s2;
    logic [STRAP_W-1:0]    strap;
    logic [STRAP_W-1:0]    next_strap;
    logic                  strap_done;
    logic [1:0]            strap_age;
    logic [CNT_W-1:0]      main_cnt;

    assign slow_rise  = rtc_edge.rise; // RQ13
    assign acc        = psel && penable && pready;
    assign wr         = acc && pwrite;
    assign tidx       = paddr[7:5];
    assign tfld       = paddr[3:2];
    assign cmp_active = |int_en;
    // In slow mode the parked fast count is stale
    assign main_cnt = (state == ST_FAST) ? fast_cnt
                                         : slow_cnt[SLOW_W-1:FRAC_W]; // RQ20

    // -------------------------------------------------------------------
    // Comparators
    // -------------------------------------------------------------------
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_cmp
        assign match[g] = count_en && (state == ST_FAST)
                          && (fast_cnt == cmp[g]); // RQ1
    end

    // -------------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------------
    // One wait state: answer comes on the second access cycle
    always_comb begin
        next_pready  = psel && penable && !pready;
        next_prdata  = 32'h0;
        next_pslverr = 1'b0;
        if (next_pready) begin
            case (paddr)
                GEN_CTRL_OFS: begin
                    next_prdata[CTRL_EN_BIT]     = count_en;
                    next_prdata[CTRL_LEGACY_BIT] = legacy_route_sel;
                end
                GEN_STAT_OFS: begin
                    next_prdata[NUM_TIMERS-1:0] = hit;
                    next_prdata[STAT_SLOW_BIT]  = slow_mode_active;
                    next_prdata[STAT_PARK_BIT]  = (state == ST_PARKED);
                    next_prdata[STAT_STRAP_LSB +: STRAP_W] = strap; // RQ5
                    next_prdata[STAT_BUSY_BIT]  = cmp_active;
                end
                COUNT_LO_OFS: next_prdata = main_cnt[31:0]; // RQ3
                COUNT_HI_OFS: next_prdata = main_cnt[63:32];
                default: begin
                    if (is_tmr(paddr)) begin
                        case (tfld)
                            TMR_CFG_FLD: begin
                                next_prdata[CFG_INT_EN_BIT] = int_en[tidx];
                                next_prdata[CFG_PERIOD_BIT] =
                                    (tidx == 3'h0) && periodic0;
                            end
                            TMR_CMPLO_FLD: next_prdata = cmp[tidx][31:0];
                            TMR_CMPHI_FLD: next_prdata = cmp[tidx][63:32];
                            default:       next_prdata = 32'h0;
                        endcase
                    end else begin
                        next_pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // -------------------------------------------------------------------
    // Control, comparator values and match flags
    // -------------------------------------------------------------------
    always_comb begin
        next_count_en  = count_en;
        next_legacy    = legacy_route_sel;
        next_period0   = period0;
        next_periodic0 = periodic0;
        next_int_en    = int_en;
        next_hit       = hit;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            next_cmp[i] = cmp[i];
        end
        if (wr && paddr == GEN_CTRL_OFS) begin
            next_count_en = pwdata[CTRL_EN_BIT];
            next_legacy   = pwdata[CTRL_LEGACY_BIT];
        end
        // Clear first so a match in the same cycle survives
        if (wr && paddr == GEN_STAT_OFS) begin
            next_hit = hit & ~pwdata[NUM_TIMERS-1:0];
        end
        if (wr && is_tmr(paddr)) begin
            case (tfld)
                TMR_CFG_FLD: begin
                    next_int_en[tidx] = pwdata[CFG_INT_EN_BIT];
                    if (tidx == 3'h0) begin
                        next_periodic0 = pwdata[CFG_PERIOD_BIT]; // RQ2
                    end
                end
                TMR_CMPLO_FLD: begin
                    next_cmp[tidx][31:0] = pwdata;
                    if (tidx == 3'h0) begin
                        next_period0[31:0] = pwdata;
                    end
                end
                TMR_CMPHI_FLD: begin
                    next_cmp[tidx][63:32] = pwdata;
                    if (tidx == 3'h0) begin
                        next_period0[63:32] = pwdata;
                    end
                end
                default: ;
            endcase
        end
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (match[i]) begin
                next_hit[i] = 1'b1; // RQ1
            end
        end
        if (match[0] && periodic0) begin
            next_cmp[0] = cmp[0] + period0; // RQ2
        end
        next_irq = next_hit & next_int_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_en         <= 1'b0;
            legacy_route_sel <= 1'b0;
            period0          <= COUNT_RST;
            periodic0        <= 1'b0;
            int_en           <= '0;
            hit              <= '0;
            timer_irq        <= '0;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                cmp[i] <= CMP_RST;
            end
        end else begin
            count_en         <= next_count_en;
            legacy_route_sel <= next_legacy;
            period0          <= next_period0;
            periodic0        <= next_periodic0;
            int_en           <= next_int_en;
            hit              <= next_hit;
            timer_irq        <= next_irq;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                cmp[i] <= next_cmp[i];
            end
        end
    end

    // -------------------------------------------------------------------
    // Main counter and off-load sequencer
    // -------------------------------------------------------------------
    always_comb begin
        logic [SLOW_W-1:0] sum;
        sum         = slow_cnt + SLOW_W'(cal_step);
        next_state  = state;
        next_fast   = fast_cnt;
        next_slow   = slow_cnt;
        next_active = slow_mode_active;
        case (state)
            ST_FAST: begin
                if (count_en) begin
                    next_fast = fast_cnt + 64'h1; // RQ6 RQ4
                end
                if (wr && paddr == COUNT_LO_OFS) begin
                    next_fast[31:0] = pwdata;
                end
                if (wr && paddr == COUNT_HI_OFS) begin
                    next_fast[63:32] = pwdata;
                end
                // Armed comparators need the fast clock to stay up
                if (slow_rise && offload_req && !cmp_active) begin // RQ7
                    next_fast   = fast_cnt; // RQ15
                    next_slow   = {fast_cnt, slow_cnt[FRAC_W-1:0]}; // RQ14
                    next_state  = ST_PARKED;
                    next_active = 1'b1; // RQ12
                end
            end
            ST_PARKED: begin
                if (slow_rise) begin
                    next_slow = sum; // RQ15
                    if (offload_req) begin
                        next_state = ST_SLOW;
                    end else begin
                        next_fast   = sum[SLOW_W-1:FRAC_W]; // RQ18
                        next_state  = ST_FAST;
                        next_active = 1'b0;
                    end
                end
            end
            ST_SLOW: begin
                if (slow_rise) begin // RQ11
                    if (offload_req) begin
                        next_slow = sum; // RQ10
                    end else begin
                        next_fast   = slow_cnt[SLOW_W-1:FRAC_W]; // RQ16
                        next_state  = ST_FAST;
                        next_active = 1'b0;
                    end
                end
            end
            default: begin
                next_state  = ST_FAST;
                next_active = 1'b0;
            end
        endcase
    end

    // Fraction is cleared only by reset, then carried across entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= ST_FAST;
            fast_cnt         <= COUNT_RST;
            slow_cnt         <= SLOW_RST; // RQ17
            slow_mode_active <= 1'b0;
        end else begin
            state            <= next_state;
            fast_cnt         <= next_fast;
            slow_cnt         <= next_slow;
            slow_mode_active <= next_active;
        end
    end

    // -------------------------------------------------------------------
    // Frequency strap, caught once after reset release
    // -------------------------------------------------------------------
    always_comb begin
        next_strap = strap_done ? strap : strap_s2; // RQ5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1   <= '0;
            strap_s2   <= '0;
            strap      <= '0;
            strap_done <= 1'b0;
            strap_age  <= '0;
        end else begin
            strap_s1   <= xtal_freq_strap;
            strap_s2   <= strap_s1;
            strap      <= next_strap;
            // Lock only once both sync stages hold the pin value
            strap_age  <= {strap_age[0], 1'b1};
            strap_done <= strap_age[1];
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fast_inc;
        (state == ST_FAST) && count_en && !slow_rise && !wr
            |=> fast_cnt == $past(fast_cnt) + 64'h1;
    endproperty
    a_fast_inc: assert property (p_fast_inc) // RQ6
        else $error("fast count did not advance by one");

    property p_refuse;
        (state == ST_FAST) && cmp_active |=> state == ST_FAST;
    endproperty
    a_refuse: assert property (p_refuse) // RQ7
        else $error("off-load entered with a comparator armed");

    property p_slow_add;
        (state == ST_SLOW) && slow_rise && offload_req
            |=> slow_cnt == $past(slow_cnt) + SLOW_W'($past(cal_step));
    endproperty
    a_slow_add: assert property (p_slow_add) // RQ10
        else $error("slow count did not add calibration step");

    property p_edge_only;
        $changed(slow_mode_active) |-> $past(slow_rise);
    endproperty
    a_edge_only: assert property (p_edge_only) // RQ11
        else $error("mode switched without slow edge");

    property p_entry;
        (state == ST_FAST) && (next_state == ST_PARKED)
            |=> slow_cnt[SLOW_W-1:FRAC_W] == $past(fast_cnt)
                && slow_cnt[FRAC_W-1:0] == $past(slow_cnt[FRAC_W-1:0]);
    endproperty
    a_entry: assert property (p_entry) // RQ14
        else $error("entry copy or fraction wrong");

    property p_park;
        (state == ST_PARKED) && !slow_rise
            |=> $stable(fast_cnt) && $stable(slow_cnt);
    endproperty
    a_park: assert property (p_park) // RQ15
        else $error("parked count moved");

    property p_exit;
        (state == ST_SLOW) && slow_rise && !offload_req
            |=> fast_cnt == $past(slow_cnt[SLOW_W-1:FRAC_W])
                && !slow_mode_active && state == ST_FAST;
    endproperty
    a_exit: assert property (p_exit) // RQ16
        else $error("exit reload wrong");

    property p_quick;
        (state == ST_PARKED) && slow_rise && !offload_req
            |=> state == ST_FAST && !slow_mode_active;
    endproperty
    a_quick: assert property (p_quick) // RQ18
        else $error("early exit did not finish on one edge");

    property p_period;
        match[0] && periodic0 |=> cmp[0] == $past(cmp[0]) + $past(period0);
    endproperty
    a_period: assert property (p_period) // RQ2
        else $error("periodic reload wrong");

endmodule : offload_event_timer

// ===== bench/pmc_model.sv
// Power management controller model: slow clock, off-load request, step
module pmc_model (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  want_idle,
    output logic       rtc_clk,
    output logic       offload_req,
    output logic [27:0] cal_step
);
    timeunit 1ns;
    timeprecision 1ps;

    // Slow clock runs free, unrelated in phase to pclk
    initial begin
        rtc_clk = 1'b0;
        #7;
        forever #15259 rtc_clk = ~rtc_clk;
    end

    // Integer part 42 per slow edge, empty fraction keeps sums exact
    assign cal_step = 28'h0a8_0000;

    // Raised only once the bench reports no wake event and no
    // calibration, then held for the whole idle spell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offload_req <= 1'b0;
        end else begin
            offload_req <= want_idle;
        end
    end
endmodule : pmc_model

// ===== bench/offloadable_event_timer_counter_test.sv
// Self-checking bench of the off-loadable event timer
module offloadable_event_timer_counter_test
    import evt_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, rtc_clk, offload_req, want;
    logic [27:0] cal_step;
    logic        slow_mode_active, legacy_route_sel;
    logic [7:0]  timer_irq;
    logic [31:0] p1, f;
    int          err_total, n_compared;

    offload_event_timer u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rtc_clk(rtc_clk),
        .offload_req(offload_req), .cal_step(cal_step),
        .xtal_freq_strap(2'b01), .slow_mode_active(slow_mode_active),
        .timer_irq(timer_irq), .legacy_route_sel(legacy_route_sel)
    );

    pmc_model u_pmc (
        .pclk(pclk), .presetn(presetn), .want_idle(want),
        .rtc_clk(rtc_clk), .offload_req(offload_req), .cal_step(cal_step)
    );

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic timeout(input string s);
        err_total++;
        $display("BAD %s expected done seen timeout", s);
        stop_test;
    endtask : timeout

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // ------------------------------------------------------------------
    // APB master: entered just after a rising edge, holds until pready
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) timeout("pready");
        rd = prdata;
        er = pslverr;
    endtask : apb

    task automatic rel;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : rel

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        rel;
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        rel;
    endtask : rdr

    task automatic wait_slow(input logic v);
        int n;
        n = 0;
        while (slow_mode_active !== v && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) timeout("slow_mode_active");
    endtask : wait_slow

    // Polls the count until a slow edge moves it
    task automatic next_val(input logic [31:0] old);
        int n;
        n = 0;
        do begin
            rdr(COUNT_LO_OFS);
            n++;
        end while (rd === old && n < 4000);
        if (n >= 4000) timeout("slow step");
    endtask : next_val

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdr(GEN_CTRL_OFS);
        chk("gen_ctrl", 32'h0, rd);
        rdr(12'h108);
        chk("cmp0_lo", CMP_RST[31:0], rd);
        rdr(COUNT_LO_OFS);
        chk("count_lo", 32'h0, rd);
        rdr(12'h0f0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        wr(GEN_CTRL_OFS, 32'h1);
        apb(1'b0, COUNT_LO_OFS, 32'h0);
        f = rd;
        apb(1'b0, COUNT_LO_OFS, 32'h0);
        rel;
        chk("count_step", f + 32'h3, rd);
        wr(GEN_CTRL_OFS, 32'h3);
        chk("legacy_on", 32'h1, {31'h0, legacy_route_sel});
        wr(GEN_CTRL_OFS, 32'h1);
        chk("legacy_off", 32'h0, {31'h0, legacy_route_sel});
        $display("test count done");
    endtask : t_count

    task automatic t_timer;
        int n;
        rdr(COUNT_LO_OFS);
        f  = rd;
        p1 = rd + 32'd60;
        wr(12'h12c, 32'h0);
        wr(12'h128, f + 32'd100);
        wr(12'h120, 32'h3);
        wr(12'h10c, 32'h0);
        wr(12'h108, p1);
        wr(12'h100, 32'h2);
        rdr(12'h120);
        chk("tmr1_cfg", 32'h1, rd);
        n = 0;
        while (timer_irq[1] !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk("irq", 32'h2, {24'h0, timer_irq});
        rdr(GEN_STAT_OFS);
        // Timer 0 matched too, unarmed, and moved on by its period
        chk("match_flags", 32'h3, {24'h0, rd[7:0]});
        rdr(12'h108);
        chk("tmr0_period", p1 + p1, rd);
        $display("test timer done");
    endtask : t_timer

    task automatic t_refuse;
        int n;
        want <= 1'b1;
        for (n = 0; n < 13000; n++) begin
            @(posedge pclk);
            if (slow_mode_active !== 1'b0) break;
        end
        chk("refused", 32'h0, {31'h0, slow_mode_active});
        rdr(GEN_STAT_OFS);
        chk("armed", 32'h1, {31'h0, rd[STAT_BUSY_BIT]});
        rdr(COUNT_LO_OFS);
        f = rd;
        wr(12'h120, 32'h0);
        wr(GEN_STAT_OFS, 32'h2);
        chk("irq_clr", 32'h0, {24'h0, timer_irq});
        rdr(GEN_STAT_OFS);
        chk("flag_clr", 32'h0, {31'h0, rd[1]});
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_offload;
        wait_slow(1'b1);
        apb(1'b0, COUNT_LO_OFS, 32'h0);
        p1 = rd;
        apb(1'b0, COUNT_LO_OFS, 32'h0);
        chk("parked", p1, rd);
        apb(1'b0, GEN_STAT_OFS, 32'h0);
        rel;
        chk("park_stat", 32'h3, {30'h0, rd[9:8]});
        chk("strap", 32'h1, {30'h0, rd[11:10]});
        chk("park_copy", 32'h1, {31'h0, p1 > f});
        next_val(p1);
        chk("slow_add1", p1 + 32'd42, rd);
        next_val(p1 + 32'd42);
        chk("slow_add2", p1 + 32'd84, rd);
        want <= 1'b0;
        wait_slow(1'b0);
        apb(1'b0, COUNT_LO_OFS, 32'h0);
        f = rd;
        rel;
        // Reload adds no step; two fast cycles pass before the read
        chk("reload", p1 + 32'd86, rd);
        rdr(COUNT_LO_OFS);
        chk("resume", f + 32'h4, rd);
        want <= 1'b1;
        wait_slow(1'b1);
        rdr(COUNT_LO_OFS);
        p1 = rd;
        want <= 1'b0;
        wait_slow(1'b0);
        rdr(COUNT_LO_OFS);
        chk("quick_exit", p1 + 32'd44, rd);
        $display("test offload done");
    endtask : t_offload

    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        want = 1'b0;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_count;
        t_timer;
        t_refuse;
        t_offload;
        stop_test;
    end
endmodule : offloadable_event_timer_counter_test
